// [srmc_sleep_regulator_mode_control.v]
// sleep-time regulator mode, wake stabilisation and fast oscillator hold
`timescale 1ns/1ns
`default_nettype none
`include "srmc_defines.vh"
module srmc_sleep_regulator_mode_control #(
    parameter UNREGULATED = 0,
    parameter STAB_CYCLES = (`SRMC_STAB_TIME_NS + `SRMC_CLK_PERIOD_NS - 1)
                            / `SRMC_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire core_clk,
    input  wire resetn,
    // core sleep control (same clock domain)
    input  wire sleep_req,
    input  wire wake_event,
    output wire core_stall,
    output wire core_asleep,
    // software mode select (same clock domain)
    input  wire sleep_regulator_lowpower_select,
    // peripheral enables (same clock domain)
    input  wire incompat_periph_en,
    input  wire brownout_reset_en,
    input  wire watchdog_timer_en,
    input  wire pin_interrupt_en,
    input  wire external_clocked_timer_en,
    input  wire complementary_waveform_unit_hfosc,
    input  wire numeric_osc_unit_hfosc,
    input  wire configurable_logic_cell_hfosc,
    // analog side (asynchronous)
    input  wire regulator_ready,
    // regulator and oscillator controls
    output wire regulator_lowpower,
    output wire reference_lowpower,
    output wire high_freq_internal_osc_sleep_on
);
    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    wire ready_sync;

    srmc_sync2 #(
        .W (1)
    ) u_ready_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .d        (regulator_ready),
        .q        (ready_sync)
    );

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam [1:0]             ST_RUN    = `SRMC_ST_RUN;
    localparam [1:0]             ST_SLEEP  = `SRMC_ST_SLEEP;
    localparam [1:0]             ST_WAKE   = `SRMC_ST_WAKE;
    localparam [`SRMC_CNT_W-1:0] STAB_LOAD = STAB_CYCLES[`SRMC_CNT_W-1:0];
    // regulated part: low power is a choice and costs a wake delay
    localparam [0:0]             REGULATED = (UNREGULATED == 0) ? 1'h1 : 1'h0;

    // ----------------------------------------------------------------
    // low-power permission
    // ----------------------------------------------------------------
    // the benign set (brown-out, watchdog, pins, ext timer) never blocks
    // low power, so those enables are ORed with a constant 1 and cannot change the term
    wire benign_only = brownout_reset_en | watchdog_timer_en
                     | pin_interrupt_en | external_clocked_timer_en
                     | 1'h1;
    wire lp_allowed  = ~REGULATED |
                       (sleep_regulator_lowpower_select
                        & ~incompat_periph_en
                        & benign_only);
    wire hfosc_hold  = complementary_waveform_unit_hfosc
                     | numeric_osc_unit_hfosc
                     | configurable_logic_cell_hfosc;

    // ----------------------------------------------------------------
    // sleep / wake sequencer
    // ----------------------------------------------------------------
    reg [1:0]             state_r;
    reg [1:0]             state_nxt;
    reg [`SRMC_CNT_W-1:0] cnt_r;
    reg [`SRMC_CNT_W-1:0] cnt_nxt;
    reg                   lp_r;
    reg                   lp_nxt;
    reg                   stab_done;

    // only a low-power sleep on a regulated part pays the wake delay
    wire                  wake_slow = wake_event & lp_r & REGULATED;

    // the stall ends on whichever comes first: synchronised ready or
    // the counter, which is the backstop if ready never rises
    always @* begin
        stab_done = 1'h0;
        if (ready_sync)
            stab_done = 1'h1;
        if (cnt_r == `SRMC_CNT_ONE)
            stab_done = 1'h1;
        if (cnt_r == `SRMC_CNT_ZERO)
            stab_done = 1'h1;
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_req)
                    state_nxt = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake_slow)
                    state_nxt = ST_WAKE;
                else if (wake_event)
                    state_nxt = ST_RUN;
            end
            ST_WAKE: begin
                if (stab_done)
                    state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // limitation: the select is only looked at on sleep entry
    always @* begin
        lp_nxt = lp_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_req)
                    lp_nxt = lp_allowed;
            end
            ST_SLEEP: begin
                // an incompatible peripheral enable appearing mid-sleep on a regulated part pulls the regulator back up
                if (incompat_periph_en && REGULATED)
                    lp_nxt = 1'h0;
                if (wake_event)
                    lp_nxt = 1'h0;
            end
            default: begin
                lp_nxt = 1'h0;
            end
        endcase
    end

    // loaded so that the stall lasts STAB_CYCLES clocks without ready
    always @* begin
        cnt_nxt = cnt_r;
        case (state_r)
            ST_SLEEP: begin
                if (wake_slow)
                    cnt_nxt = STAB_LOAD;
            end
            ST_WAKE: begin
                if (stab_done)
                    cnt_nxt = `SRMC_CNT_ZERO;
                else
                    cnt_nxt = cnt_r - `SRMC_CNT_ONE;
            end
            default: begin
                cnt_nxt = `SRMC_CNT_ZERO;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= ST_RUN;
            cnt_r   <= `SRMC_CNT_ZERO;
            lp_r    <= 1'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            lp_r    <= lp_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    reg  regulator_lowpower_r;
    reg  regulator_lowpower_nxt;
    reg  reference_lowpower_r;
    reg  reference_lowpower_nxt;
    reg  hfosc_on_r;
    reg  hfosc_on_nxt;

    // registered from the next state so they move together with core_asleep
    always @* begin
        regulator_lowpower_nxt = 1'h0;
        reference_lowpower_nxt = 1'h0;
        hfosc_on_nxt           = 1'h0;
        if (state_nxt == ST_SLEEP) begin
            regulator_lowpower_nxt = lp_nxt;
            reference_lowpower_nxt = lp_nxt;
            hfosc_on_nxt           = hfosc_hold;
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            regulator_lowpower_r <= 1'h0;
            reference_lowpower_r <= 1'h0;
            hfosc_on_r           <= 1'h0;
        end else begin
            regulator_lowpower_r <= regulator_lowpower_nxt;
            reference_lowpower_r <= reference_lowpower_nxt;
            hfosc_on_r           <= hfosc_on_nxt;
        end
    end

    assign regulator_lowpower              = regulator_lowpower_r;
    assign reference_lowpower              = reference_lowpower_r;
    assign high_freq_internal_osc_sleep_on = hfosc_on_r;
    assign core_asleep                     = (state_r == ST_SLEEP);
    assign core_stall                      = (state_r == ST_WAKE);
endmodule // srmc_sleep_regulator_mode_control
`default_nettype wire

// [srmc_defines.vh]
// constants for the sleep regulator mode control block
`ifndef SRMC_DEFINES_VH
`define SRMC_DEFINES_VH

// sequencer states
`define SRMC_ST_RUN    2'h0
`define SRMC_ST_SLEEP  2'h1
`define SRMC_ST_WAKE   2'h2

// stabilisation time in ns and clock period in ns
`define SRMC_STAB_TIME_NS   2000
`define SRMC_CLK_PERIOD_NS  10

`define SRMC_CNT_W   16
`define SRMC_CNT_ONE 16'h0001
`define SRMC_CNT_ZERO 16'h0000

`endif

// [srmc_sync2.v]
// two-flop synchroniser, one bit per lane
`timescale 1ns/1ns
`default_nettype none
module srmc_sync2 #(
    parameter W = 1
) (
    // clock and reset
    input  wire         core_clk,
    input  wire         resetn,
    // data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge core_clk) begin
        if (!resetn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule // srmc_sync2
`default_nettype wire

// [srmc_monitor.sv]
// port assertions for the sleep regulator mode control block
`timescale 1ns/1ns
`default_nettype none
module srmc_monitor (
    // clock, reset and sleep handshake
    input wire logic core_clk, resetn, sleep_req, wake_event, core_stall, core_asleep,
    // mode select, enables and regulator outputs
    input wire logic sleep_regulator_lowpower_select, incompat_periph_en,
    input wire logic complementary_waveform_unit_hfosc, numeric_osc_unit_hfosc,
    input wire logic configurable_logic_cell_hfosc, regulator_lowpower,
    input wire logic reference_lowpower, high_freq_internal_osc_sleep_on
);
    wire logic hf = complementary_waveform_unit_hfosc | numeric_osc_unit_hfosc
                    | configurable_logic_cell_hfosc;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_enter;
        !core_asleep && !core_stall && sleep_req;
    endsequence
    sequence s_wake;
        core_asleep && wake_event;
    endsequence
    AST_LP: assert property (
        s_enter ##0 (sleep_regulator_lowpower_select && !incompat_periph_en)
        |=> core_asleep && regulator_lowpower) else $error("low power not entered");
    AST_NORM: assert property (
        s_enter ##0 !sleep_regulator_lowpower_select |=> core_asleep && !regulator_lowpower)
        else $error("normal sleep not kept");
    AST_INC: assert property (
        incompat_periph_en |=> !regulator_lowpower) else $error("low power with blocker");
    AST_REF: assert property (
        (regulator_lowpower == reference_lowpower) && (!regulator_lowpower || core_asleep))
        else $error("reference mode mismatch");
    AST_FAST: assert property (
        s_wake ##0 !regulator_lowpower |=> !core_asleep && !core_stall) else $error("slow wake");
    AST_SLOW: assert property (
        s_wake ##0 regulator_lowpower |=> core_stall && !core_asleep) else $error("no stall");
    AST_STAB: assert property (
        $rose(core_stall) |-> ##[1:8] !core_stall) else $error("stall too long");
    AST_OSC: assert property (
        core_asleep && $past(core_asleep) && $past(hf) |-> high_freq_internal_osc_sleep_on)
        else $error("fast oscillator dropped");
endmodule // srmc_monitor
bind srmc_sleep_regulator_mode_control srmc_monitor srmc_monitor_i (.*);
`default_nettype wire

// [srmc_reg_model.sv]
// regulator model: ready returns a few cycles after low power is released
`timescale 1ns/1ns
`default_nettype none
module srmc_reg_model #(parameter DLY = 2) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // regulator side
    input  wire logic regulator_lowpower,
    output wire logic regulator_ready
);
    int cnt_r;
    // never ready at once, so the wake stall is really needed
    always @(posedge core_clk) begin
        if (!resetn || regulator_lowpower) cnt_r <= DLY;
        else if (cnt_r > 0) cnt_r <= cnt_r - 1;
    end
    assign regulator_ready = (cnt_r == 0) && !regulator_lowpower;
endmodule // srmc_reg_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the sleep regulator mode control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic core_clk = 0, resetn = 0, slp = 0, wk = 0, sel = 0, inc = 0, e;
    logic [3:0] ben = 0;
    logic [2:0] hf = 0;
    logic [31:0] r;
    wire stall, asleep, rlp, flp, osc, rdy;
    int fail_count = 0, n_checks = 0, i, w;
    initial forever #5 core_clk = ~core_clk;
    srmc_sleep_regulator_mode_control #(.STAB_CYCLES(8)) srmc_sleep_regulator_mode_control_i (
        .core_clk(core_clk), .resetn(resetn), .sleep_req(slp), .wake_event(wk),
        .core_stall(stall), .core_asleep(asleep), .sleep_regulator_lowpower_select(sel),
        .incompat_periph_en(inc), .brownout_reset_en(ben[0]), .watchdog_timer_en(ben[1]),
        .pin_interrupt_en(ben[2]), .external_clocked_timer_en(ben[3]),
        .complementary_waveform_unit_hfosc(hf[0]), .numeric_osc_unit_hfosc(hf[1]),
        .configurable_logic_cell_hfosc(hf[2]), .regulator_ready(rdy),
        .regulator_lowpower(rlp), .reference_lowpower(flp),
        .high_freq_internal_osc_sleep_on(osc));
    srmc_reg_model srmc_reg_model_i (.core_clk(core_clk), .resetn(resetn),
        .regulator_lowpower(rlp), .regulator_ready(rdy));
    task automatic chk(input logic s, input logic x);
        n_checks++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value at %0t in check %0d", $time, n_checks);
        end
    endtask
    function automatic logic exp_lp(input logic s, input logic b);
        return s & ~b;
    endfunction
    // ready after two model cycles, two sync flops, one cycle to leave
    function automatic int stall_len(input logic slow);
        return slow ? 5 : 0;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        results();
    end
    initial begin
        w = $urandom(3);
        cyc(5);
        resetn = 1;
        for (i = 0; i < 20; i++) begin
            r = $urandom;
            {sel, inc, ben, hf} = r[8:0];
            if (i < 3) begin
                sel = 1;
                inc = (i == 1);
            end
            slp = 1;
            cyc(1);
            slp = 0;
            cyc(1);
            chk(asleep, 1'b1);
            chk(rlp, exp_lp(sel, inc));
            chk(flp, exp_lp(sel, inc));
            chk(osc, |hf);
            if (i == 2) begin
                inc = 1;
                cyc(2);
                chk(rlp, 1'b0);
            end
            e = exp_lp(sel, inc);
            wk = 1;
            cyc(1);
            wk = 0;
            chk(asleep, 1'b0);
            chk(stall, e);
            for (w = 0; w < 12 && stall === 1'b1; w++) cyc(1);
            chk(w == stall_len(e), 1'b1);
            chk(rlp, 1'b0);
            cyc(i % 2);
        end
        results();
    end
endmodule // tb
`default_nettype wire
